// *** inc/pwm_sysclk_pkg.sv ***
// Constants and types for the system clock PWM generator with sync
// What this block does
// - Run bit 2 of the control register starts and stops the period counter.
// - Divider select 00,01,10,11 divides the counter tick by 1,4,8,16.
// - Control register bits 7 to 3 always read back as zero.
// - Generated clock sets frequency and caps drive duty at the duty limit.
// - Stand-alone: clock runs at programmed period and duty, never retuned.
// - Sync master also drives its system clock onto the sync pin.
// - Sync slave ORs master clock with own wrap to load duty and phase.
// - Slave clock start lags master clock by phase times tick period.
// - Period is limit plus one, times oscillator period times divider.
// - At match, next tick clears counter and copies duty buffer to active.
// - High time equals duty value times oscillator period times divider.
// - Duty buffer writes take effect only after the next counter match or, as slave, master edge.
// - In sleep counting stops, state and output level hold, then resume.
// - Reset loads counter 00h and limit FFh; both are read/write.
// - Prescaler clears on counter write, control write and reset.
// - Every counter match sets the period match flag; software clears it.
`default_nettype none

package pwm_sysclk_pkg;

  // Register bus request as seen by the slave port
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Register offsets
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_LIMIT = 3'h1;
  localparam logic [2:0] ADDR_DUTY_BUF = 3'h2;
  localparam logic [2:0] ADDR_PHASE_BUF = 3'h3;
  localparam logic [2:0] ADDR_COUNTER = 3'h4;
  localparam logic [2:0] ADDR_MODE = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [2:0] ADDR_DUTY_ACT = 3'h7;

  // Field positions
  localparam int RUN_BIT = 2;
  localparam int FLAG_BIT = 0;

  // Values after reset
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] LIMIT_RST = 8'hFF;
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [3:0] PRESC_RST = 4'h0;

  // Prescaler terminal counts for divide by 1, 4, 8 and 16
  localparam logic [3:0] DIV1_MAX = 4'h0;
  localparam logic [3:0] DIV4_MAX = 4'h3;
  localparam logic [3:0] DIV8_MAX = 4'h7;
  localparam logic [3:0] DIV16_MAX = 4'hF;

  // Synchronisation role; code 3 behaves as stand-alone
  typedef enum logic [1:0] {
    MODE_ALONE = 2'h0,
    MODE_MASTER = 2'h1,
    MODE_SLAVE = 2'h2
  } sync_mode_t;

  // Slave phase delay sequencer
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_WAIT = 2'b10
  } phase_state_t;

endpackage

`default_nettype wire

// *** logic/pwm_sysclk.sv ***
// System clock PWM generator with period timer, prescaler and sync pin
`default_nettype none

module pwm_sysclk (
  input wire logic clock,
  input wire logic nrst,
  input wire pwm_sysclk_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic sleep_mode,
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe,
  output logic clock_out_pin,
  output logic period_match_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [2:0] ctrl_r;
  logic [7:0] limit_r;
  logic [7:0] duty_buf_r;
  logic [7:0] phase_buf_r;
  logic [7:0] counter_r;
  logic [7:0] counter_nxt;
  logic [1:0] mode_r;
  logic [7:0] duty_act_r;
  logic [7:0] duty_act_nxt;
  logic [7:0] phase_act_r;
  logic [7:0] phase_wait_r;
  logic [7:0] phase_wait_nxt;
  logic [3:0] presc_r;
  logic [3:0] presc_nxt;
  logic flag_r;
  logic out_r;
  logic out_nxt;
  logic [7:0] rdata_r;
  logic sync_meta_r;
  logic sync_sync_r;
  logic sync_prev_r;
  pwm_sysclk_pkg::phase_state_t ph_state_r;
  pwm_sysclk_pkg::phase_state_t ph_state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire wr_ctrl = req.wr && (req.addr == pwm_sysclk_pkg::ADDR_CTRL);
  wire wr_limit = req.wr && (req.addr == pwm_sysclk_pkg::ADDR_LIMIT);
  wire wr_duty = req.wr && (req.addr == pwm_sysclk_pkg::ADDR_DUTY_BUF);
  wire wr_phase = req.wr && (req.addr == pwm_sysclk_pkg::ADDR_PHASE_BUF);
  wire wr_counter = req.wr && (req.addr == pwm_sysclk_pkg::ADDR_COUNTER);
  wire wr_mode = req.wr && (req.addr == pwm_sysclk_pkg::ADDR_MODE);
  wire wr_status = req.wr && (req.addr == pwm_sysclk_pkg::ADDR_STATUS);
  wire flag_clear = wr_status && req.wdata[pwm_sysclk_pkg::FLAG_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Mode and tick generation

  wire run = ctrl_r[pwm_sysclk_pkg::RUN_BIT];
  wire [1:0] div_sel = ctrl_r[1:0];
  wire is_master = (mode_r == pwm_sysclk_pkg::MODE_MASTER);
  wire is_slave = (mode_r == pwm_sysclk_pkg::MODE_SLAVE);
  // Counting is frozen in sleep so the timer state holds; the sync pin synchroniser keeps sampling
  wire active = run && !sleep_mode;

  wire [3:0] presc_max =
    (div_sel == 2'h0) ? pwm_sysclk_pkg::DIV1_MAX :
    (div_sel == 2'h1) ? pwm_sysclk_pkg::DIV4_MAX :
    (div_sel == 2'h2) ? pwm_sysclk_pkg::DIV8_MAX :
    pwm_sysclk_pkg::DIV16_MAX;

  wire tick = active && (presc_r == presc_max);

  assign presc_nxt =
    (wr_ctrl || wr_counter) ? pwm_sysclk_pkg::PRESC_RST :
    !active ? presc_r :
    tick ? pwm_sysclk_pkg::PRESC_RST :
    4'(presc_r + 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Master clock edge from the sync pin

  // Rising edge of the synchronised pin; ignored in sleep to hold state
  wire master_edge = is_slave && !sleep_mode && sync_sync_r && !sync_prev_r;

  // Two-stage synchroniser, the edge detector reads only the second stage
  // Reset high like the pulled-up idle pin, so no false edge follows reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_meta_r <= 1'b1;
      sync_sync_r <= 1'b1;
      sync_prev_r <= 1'b1;
    end else begin
      sync_meta_r <= sync_clock_pin_i;
      sync_sync_r <= sync_meta_r;
      sync_prev_r <= sync_sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period match, buffer loads and restart

  wire match = (counter_r == limit_r);
  // wrap after limit plus one ticks
  wire own_wrap = tick && match;
  // master edge ORed with own wrap
  wire load_evt = own_wrap || master_edge;
  // A zero phase restarts on the edge itself; otherwise the wait counts down
  wire phase_zero_start = master_edge && (phase_buf_r == 8'h00);
  wire phase_done = (ph_state_r == pwm_sysclk_pkg::PH_WAIT) && tick &&
                    (phase_wait_r == 8'h00);
  wire restart = own_wrap || phase_done || phase_zero_start;

  assign duty_act_nxt = load_evt ? duty_buf_r : duty_act_r;

  assign counter_nxt =
    wr_counter ? req.wdata :
    restart ? pwm_sysclk_pkg::COUNTER_RST :
    tick ? 8'(counter_r + 8'h01) :
    counter_r;

  // Phase sequencer: arm on master edge, count down on ticks
  always_comb begin
    ph_state_nxt = ph_state_r;
    phase_wait_nxt = phase_wait_r;
    unique case (ph_state_r)
      pwm_sysclk_pkg::PH_IDLE: begin
        if (master_edge && !phase_zero_start) begin
          ph_state_nxt = pwm_sysclk_pkg::PH_WAIT;
          phase_wait_nxt = 8'(phase_buf_r - 8'h01);
        end
      end
      pwm_sysclk_pkg::PH_WAIT: begin
        if (!is_slave || phase_done || phase_zero_start) begin
          ph_state_nxt = pwm_sysclk_pkg::PH_IDLE;
        end else if (master_edge) begin
          phase_wait_nxt = 8'(phase_buf_r - 8'h01);
        end else if (tick) begin
          phase_wait_nxt = 8'(phase_wait_r - 8'h01);
        end
      end
      default: begin
        ph_state_nxt = pwm_sysclk_pkg::PH_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock set/reset latch

  // clear as the counter steps onto the duty value
  // High therefore covers counts 0 to duty-1, exactly duty ticks
  wire duty_hit = tick && (8'(counter_r + 8'h01) == duty_act_r);

  // set on restart, reset at duty
  // A zero duty keeps the output low, a duty above the limit keeps it high
  assign out_nxt =
    restart ? (duty_act_nxt != 8'h00) :
    duty_hit ? 1'b0 :
    out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // reset values of control, limit, duty and phase buffers and mode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= pwm_sysclk_pkg::CTRL_RST;
      limit_r <= pwm_sysclk_pkg::LIMIT_RST;
      duty_buf_r <= pwm_sysclk_pkg::DUTY_RST;
      phase_buf_r <= pwm_sysclk_pkg::PHASE_RST;
      mode_r <= pwm_sysclk_pkg::MODE_ALONE;
    end else begin
      if (wr_ctrl) ctrl_r <= req.wdata[2:0];
      if (wr_limit) limit_r <= req.wdata;
      if (wr_duty) duty_buf_r <= req.wdata;
      if (wr_phase) phase_buf_r <= req.wdata;
      if (wr_mode) mode_r <= req.wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer core

  // Core state; all next values already hold in sleep
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      counter_r <= pwm_sysclk_pkg::COUNTER_RST;
      presc_r <= pwm_sysclk_pkg::PRESC_RST;
      duty_act_r <= pwm_sysclk_pkg::DUTY_RST;
      phase_act_r <= pwm_sysclk_pkg::PHASE_RST;
      phase_wait_r <= pwm_sysclk_pkg::PHASE_RST;
      ph_state_r <= pwm_sysclk_pkg::PH_IDLE;
      out_r <= 1'b0;
    end else begin
      counter_r <= counter_nxt;
      presc_r <= presc_nxt;
      duty_act_r <= duty_act_nxt;
      if (load_evt) phase_act_r <= phase_buf_r;
      phase_wait_r <= phase_wait_nxt;
      ph_state_r <= ph_state_nxt;
      out_r <= out_nxt;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= own_wrap || (flag_r && !flag_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back

  wire [7:0] rd_mux =
    (req.addr == pwm_sysclk_pkg::ADDR_CTRL) ? {5'h00, ctrl_r} :
    (req.addr == pwm_sysclk_pkg::ADDR_LIMIT) ? limit_r :
    (req.addr == pwm_sysclk_pkg::ADDR_DUTY_BUF) ? duty_buf_r :
    (req.addr == pwm_sysclk_pkg::ADDR_PHASE_BUF) ? phase_buf_r :
    (req.addr == pwm_sysclk_pkg::ADDR_COUNTER) ? counter_r :
    (req.addr == pwm_sysclk_pkg::ADDR_MODE) ? {6'h00, mode_r} :
    (req.addr == pwm_sysclk_pkg::ADDR_STATUS) ? {7'h00, flag_r} :
    duty_act_r;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= req.rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // stand-alone output straight from the latch
  assign clock_out_pin = out_r;
  assign sync_clock_pin_o = out_r;
  assign sync_clock_pin_oe = is_master;
  assign period_match_flag = flag_r;
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_ctrl_read_zero;
    @(posedge clock) disable iff (!nrst)
    (req.rd && req.addr == pwm_sysclk_pkg::ADDR_CTRL) |=> (rdata[7:3] == 5'h00)
      && (rdata[2:0] == $past(ctrl_r));
  endproperty
  a_ctrl_read_zero: assert property (p_ctrl_read_zero)
    else $error("control readback upper bits not zero");

  property p_wrap_load;
    @(posedge clock) disable iff (!nrst)
    (own_wrap && !wr_counter) |=> (counter_r == 8'h00) &&
      (duty_act_r == $past(duty_buf_r)) && period_match_flag;
  endproperty
  a_wrap_load: assert property (p_wrap_load)
    else $error("match did not clear counter or load duty");

  property p_stop_holds;
    @(posedge clock) disable iff (!nrst)
    (!run && !wr_counter && !is_slave) |=> $stable(counter_r);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("counter moved while stopped");

  property p_duty_only_on_load;
    @(posedge clock) disable iff (!nrst)
    !load_evt |=> $stable(duty_act_r);
  endproperty
  a_duty_only_on_load: assert property (p_duty_only_on_load)
    else $error("active duty changed mid period");

  property p_master_pin;
    @(posedge clock) disable iff (!nrst)
    is_master |-> sync_clock_pin_oe && (sync_clock_pin_o == clock_out_pin);
  endproperty
  a_master_pin: assert property (p_master_pin)
    else $error("master does not drive sync pin");

  property p_sleep_holds;
    @(posedge clock) disable iff (!nrst)
    (sleep_mode && !req.wr) |=> $stable(counter_r) && $stable(clock_out_pin)
      && $stable(presc_r);
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("state changed in sleep");

  property p_presc_clear;
    @(posedge clock) disable iff (!nrst)
    (wr_ctrl || wr_counter) |=> (presc_r == 4'h0);
  endproperty
  a_presc_clear: assert property (p_presc_clear)
    else $error("prescaler not cleared by write");

  property p_div_four;
    @(posedge clock) disable iff (!nrst)
    (tick && div_sel == 2'h1 && run && !sleep_mode && !req.wr) ##1
      (active && !req.wr) [*4] |-> tick;
  endproperty
  a_div_four: assert property (p_div_four)
    else $error("divide by four tick spacing wrong");

  property p_restart_high;
    @(posedge clock) disable iff (!nrst)
    (restart && duty_act_nxt != 8'h00) |=> clock_out_pin;
  endproperty
  a_restart_high: assert property (p_restart_high)
    else $error("clock not set at restart");

  property p_duty_low;
    @(posedge clock) disable iff (!nrst)
    (duty_hit && !restart) |=> !clock_out_pin;
  endproperty
  a_duty_low: assert property (p_duty_low)
    else $error("clock not reset at duty value");

  property p_flag_set_wins;
    @(posedge clock) disable iff (!nrst)
    (own_wrap && flag_clear) |=> period_match_flag;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("match flag lost against clear");

  c_wrap: cover property (@(posedge clock) disable iff (!nrst) own_wrap);
  c_slave_edge: cover property (@(posedge clock) disable iff (!nrst)
    master_edge && !phase_zero_start);
  c_phase_done: cover property (@(posedge clock) disable iff (!nrst)
    phase_done);
  c_sleep_high: cover property (@(posedge clock) disable iff (!nrst)
    sleep_mode && clock_out_pin);

endmodule

`default_nettype wire

// *** sim/peer_sync_master.sv ***
// Peer power controller acting as sync master on the shared sync pin
`default_nettype none

module peer_sync_master #(
  parameter int PERIOD = 60,
  parameter int HIGH = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  output logic drive,
  output logic level
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt_r;

  // Free period counter; restarts from zero whenever the peer is enabled
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 0;
    end else if (!enable) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
    end
  end

  // master clock source
  // Released pin is left to the pull-up, so it reads high
  assign drive = enable;
  assign level = enable ? (cnt_r < HIGH) : 1'b1;
endmodule

`default_nettype wire

// *** sim/test_pwm_sysclk.sv ***
// Self-checking bench for the system clock PWM generator
`default_nettype none

module test_pwm_sysclk;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic sleep_mode = 1'b0;
  logic peer_en = 1'b0;
  pwm_sysclk_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  logic dut_o, dut_oe, clock_out_pin, period_match_flag;
  logic peer_drive, peer_level;
  wire logic sync_pin;
  int failures = 0;
  int check_count = 0;

  // Pin level: the block wins when enabled, then the peer, else pull-up
  assign sync_pin = dut_oe ? dut_o : (peer_drive ? peer_level : 1'b1);

  pwm_sysclk dut_u (
    .clock(clock), .nrst(nrst), .req(req), .rdata(rdata),
    .sleep_mode(sleep_mode), .sync_clock_pin_i(sync_pin),
    .sync_clock_pin_o(dut_o), .sync_clock_pin_oe(dut_oe),
    .clock_out_pin(clock_out_pin), .period_match_flag(period_match_flag)
  );

  peer_sync_master peer_u (
    .clock(clock), .nrst(nrst), .enable(peer_en),
    .drive(peer_drive), .level(peer_level)
  );

  always #12.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h",
               $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  // Waits for a rising output edge, then counts high time and period
  task automatic measure(output logic [15:0] hi, output logic [15:0] per);
    int n;
    n = 0;
    hi = 0;
    per = 0;
    while (clock_out_pin !== 1'b0 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    while (clock_out_pin !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    while (clock_out_pin === 1'b1 && n < 2000) begin
      @(negedge clock);
      hi++;
      n++;
    end
    per = hi;
    while (clock_out_pin === 1'b0 && n < 2000) begin
      @(negedge clock);
      per++;
      n++;
    end
  endtask

  // Cycles from a master rising edge on the pin to the output rising
  task automatic edge_delay(output logic [15:0] d);
    int n;
    n = 0;
    d = 0;
    while (sync_pin !== 1'b0 && n < 500) begin
      @(negedge clock);
      n++;
    end
    while (sync_pin !== 1'b1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    while (clock_out_pin !== 1'b1 && d < 100) begin
      @(negedge clock);
      d++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios

  task automatic t_reset;
    rdchk(pwm_sysclk_pkg::ADDR_CTRL, 8'h00);
    rdchk(pwm_sysclk_pkg::ADDR_LIMIT, 8'hFF);
    rdchk(pwm_sysclk_pkg::ADDR_COUNTER, 8'h00);
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'hFB);
    rdchk(pwm_sysclk_pkg::ADDR_CTRL, 8'h03);
  endtask

  // Short period so all four dividers fit in a few hundred cycles
  task automatic t_divide;
    logic [15:0] divs[4] = '{16'h1, 16'h4, 16'h8, 16'h10};
    logic [15:0] hi, per;
    wr(pwm_sysclk_pkg::ADDR_LIMIT, 8'h02);
    wr(pwm_sysclk_pkg::ADDR_DUTY_BUF, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h04 | 8'(i));
      measure(hi, per);
      measure(hi, per);
      check(per, 16'h3 * divs[i]);
      check(hi, divs[i]);
    end
  endtask

  task automatic t_buffer;
    logic [15:0] hi, per;
    wr(pwm_sysclk_pkg::ADDR_LIMIT, 8'h09);
    wr(pwm_sysclk_pkg::ADDR_DUTY_BUF, 8'h03);
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h04);
    measure(hi, per);
    wr(pwm_sysclk_pkg::ADDR_DUTY_BUF, 8'h06);
    rdchk(pwm_sysclk_pkg::ADDR_DUTY_ACT, 8'h03);
    measure(hi, per);
    check(hi, 16'h6);
    check(per, 16'hA);
  endtask

  task automatic t_flag;
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h00);
    wr(pwm_sysclk_pkg::ADDR_STATUS, 8'h01);
    @(negedge clock);
    check({15'h0, period_match_flag}, 16'h0);
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h04);
    repeat (12) @(posedge clock);
    check({15'h0, period_match_flag}, 16'h1);
    rdchk(pwm_sysclk_pkg::ADDR_STATUS, 8'h01);
  endtask

  // Stop and sleep must leave the state untouched; a counter write must read back
  task automatic t_hold;
    logic [7:0] c;
    logic lvl;
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h00);
    rd(pwm_sysclk_pkg::ADDR_COUNTER, c);
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h00);
    rdchk(pwm_sysclk_pkg::ADDR_COUNTER, c);
    wr(pwm_sysclk_pkg::ADDR_COUNTER, 8'h05);
    rdchk(pwm_sysclk_pkg::ADDR_COUNTER, 8'h05);
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h04);
    @(posedge clock);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    lvl = clock_out_pin;
    rd(pwm_sysclk_pkg::ADDR_COUNTER, c);
    repeat (20) @(posedge clock);
    rdchk(pwm_sysclk_pkg::ADDR_COUNTER, c);
    check({15'h0, clock_out_pin}, {15'h0, lvl});
    @(posedge clock);
    sleep_mode <= 1'b0;
  endtask

  task automatic t_master;
    logic [15:0] mism;
    mism = 0;
    wr(pwm_sysclk_pkg::ADDR_MODE, 8'h01);
    repeat (40) begin
      @(negedge clock);
      if (dut_o !== clock_out_pin) mism++;
    end
    check({15'h0, dut_oe}, 16'h1);
    check(mism, 16'h0);
    wr(pwm_sysclk_pkg::ADDR_MODE, 8'h00);
    @(negedge clock);
    check({15'h0, dut_oe}, 16'h0);
  endtask

  // Long own period so only master edges restart the slave
  task automatic t_slave;
    logic [15:0] d0, d4;
    wr(pwm_sysclk_pkg::ADDR_LIMIT, 8'hC8);
    wr(pwm_sysclk_pkg::ADDR_DUTY_BUF, 8'h05);
    wr(pwm_sysclk_pkg::ADDR_PHASE_BUF, 8'h00);
    wr(pwm_sysclk_pkg::ADDR_MODE, 8'h02);
    wr(pwm_sysclk_pkg::ADDR_CTRL, 8'h04);
    @(posedge clock);
    peer_en <= 1'b1;
    edge_delay(d0);
    edge_delay(d0);
    wr(pwm_sysclk_pkg::ADDR_PHASE_BUF, 8'h04);
    edge_delay(d4);
    edge_delay(d4);
    check(d4 - d0, 16'h4);
    wr(pwm_sysclk_pkg::ADDR_DUTY_BUF, 8'h09);
    edge_delay(d0);
    rdchk(pwm_sysclk_pkg::ADDR_DUTY_ACT, 8'h09);
    @(posedge clock);
    peer_en <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_divide();
    t_buffer();
    t_flag();
    t_hold();
    t_master();
    t_slave();
    conclude();
  end

  // Whole run needs under a thousand cycles; allow about thirty times that
  initial begin
    #750000;
    failures++;
    conclude();
  end
endmodule

`default_nettype wire
